// *** hdl/window_watchdog_map.svh ***
// Offsets-free constant map: timing counts and field layouts of the window watchdog
`ifndef WINDOW_WATCHDOG_MAP_SVH
`define WINDOW_WATCHDOG_MAP_SVH
`define WDG_CLK_HZ 25000000
`define WDG_LONG_OPEN_MS 65
`define WDG_LONG_OPEN_CYC (`WDG_LONG_OPEN_MS * (`WDG_CLK_HZ / 1000))
`define WDG_CLOSED_MS 10
`define WDG_CLOSED_CYC (`WDG_CLOSED_MS * (`WDG_CLK_HZ / 1000))
`define WDG_OPEN_MS 20
`define WDG_OPEN_CYC (`WDG_OPEN_MS * (`WDG_CLK_HZ / 1000))
`define WDG_REG_OFF_MS 200
`define WDG_REG_OFF_CYC (`WDG_REG_OFF_MS * (`WDG_CLK_HZ / 1000))
`define WDG_RESET_PULSE_US 2
`define WDG_RESET_PULSE_CYC (`WDG_RESET_PULSE_US * (`WDG_CLK_HZ / 1000000))
`define WDG_FAILS_REG_OFF 4'h8
`define WDG_FAILS_DEEP 4'hf
`define WDG_CTRL_WIDTH 16
`define WDG_CTRL_DEFAULT 16'h0000
`define WDG_STATUS_WIDTH 8
`endif

// *** hdl/window_watchdog_pkg.sv ***
// Types shared by the window watchdog design files
package window_watchdog_pkg;
    typedef enum logic [2:0] {
        WD_OFF = 3'b000,
        WD_LONG_OPEN = 3'b001,
        WD_CLOSED = 3'b011,
        WD_OPEN = 3'b010,
        WD_REG_OFF = 3'b110,
        WD_DEEP = 3'b111
    } wd_state_type;
endpackage

// *** hdl/sync2.sv ***
// Two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic meta;
        logic stable;
    } sync_state_type;
    sync_state_type state_reg;
    sync_state_type state_next;
    always_comb begin
        state_next.meta = async_in;
        state_next.stable = state_reg.meta;
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            // Idle level of an active-low select, so no false edge follows reset
            state_reg <= '1;
        end else begin
            state_reg <= state_next;
        end
    end
    assign sync_out = state_reg.stable;
endmodule
`default_nettype wire

// *** hdl/status_flag.sv ***
// One read-and-clear status flag whose clear is ignored while the fault is still active
`timescale 1ns/1ps
`default_nettype none
module status_flag (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic fault_in,
    input wire logic clear_in,
    output logic flag_out
);
    typedef struct packed {
        logic flag;
    } flag_state_type;
    flag_state_type state_reg;
    flag_state_type state_next;
    always_comb begin
        state_next = state_reg;
        // A clear only takes when the fault is gone; a new fault wins
        if (fault_in) begin
            state_next.flag = 1'b1;
        end else if (clear_in) begin
            state_next.flag = 1'b0;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign flag_out = state_reg.flag;
endmodule
`default_nettype wire

// *** hdl/window_watchdog_failsafe.sv ***
// Window watchdog with fail-safe reaction, control write gating and status clearing
//
// Notes on behaviour
// - After reset output release in active mode, start in long open window.
// - Writing one ends the long open window and starts window mode.
// - Writing zero during long open window leaves the window running; only the toggle bit takes the zero.
// - In window mode, trigger is an inversion; repeating the value does nothing.
// - Trigger is taken only at the frame select rising edge ending the frame.
// - Failure on closed-window toggle, open window timeout, or long open timeout.
// - After 8 consecutive failures, regulator off 200ms, then back on.
// - 7 more consecutive failures, 15 total, enter deep standby.
// - Failure count increments per failure, clears on valid trigger.
// - Failure pulses reset output, restarts long open window (except at counts 8 and 15), latches fail-safe flag.
// - Compare bit one: watchdog off in light standby, long open after wake.
// - Compare bit zero: keep running while load current above threshold, else off.
// - Compare bit zero: re-enable automatically when load current rises above threshold.
// - Watchdog always disabled in flash mode; the code keeps the regulator-off period and deep standby running in flash mode.
// - Watchdog off bit set in flash mode keeps watchdog off in active mode.
// - In fail-safe, only toggle, standby request, standby select and drain fault disable bits are writable.
// - Entering fail-safe resets other controls, disables pump, back-EMF, amp, drivers.
// - Clear takes only if fault ended first; not-ready self-clears on pump voltage.
// - Read-and-clear is per bit, touching only selected flags.
`timescale 1ns/1ps
`default_nettype none
`include "window_watchdog_map.svh"
module window_watchdog_failsafe #(
    parameter logic [31:0] LONG_OPEN_CYC = `WDG_LONG_OPEN_CYC,
    parameter logic [31:0] CLOSED_CYC = `WDG_CLOSED_CYC,
    parameter logic [31:0] OPEN_CYC = `WDG_OPEN_CYC,
    parameter logic [31:0] REG_OFF_CYC = `WDG_REG_OFF_CYC
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic frame_select_pin_in,
    input wire logic frame_toggle_write_in,
    input wire logic frame_toggle_value_in,
    input wire logic frame_ctrl_write_in,
    input wire logic [15:0] frame_ctrl_data_in,
    input wire logic frame_standby_write_in,
    input wire logic frame_standby_request_in,
    input wire logic frame_standby_select_in,
    input wire logic frame_clear_in,
    input wire logic [7:0] frame_clear_mask_in,
    input wire logic flash_mode_in,
    input wire logic light_standby_in,
    input wire logic wake_event_in,
    input wire logic standby_current_compare_bit_in,
    input wire logic regulator_load_current_high_in,
    input wire logic watchdog_off_bit_in,
    input wire logic drain_fault_disable_bit_in,
    input wire logic charge_pump_above_low_in,
    input wire logic [6:0] fault_active_in,
    output logic reset_out_pin_out,
    output logic regulator_enable_out,
    output logic deep_standby_out,
    output logic failsafe_state_out,
    output logic watchdog_toggle_bit_out,
    output logic [3:0] failure_count_field_out,
    output logic [15:0] ctrl_word_out,
    output logic drain_fault_disable_bit_out,
    output logic standby_request_bit_out,
    output logic standby_select_bit_out,
    output logic blocks_enable_out,
    output logic gate_discharge_out,
    output logic [7:0] status_flags_out,
    output logic watchdog_active_out
);
    typedef struct packed {
        window_watchdog_pkg::wd_state_type state;
        logic [31:0] count;
        logic [3:0] fails;
        logic toggle;
        logic reset_pin;
        logic [7:0] reset_cnt;
        logic failsafe;
        logic wdg_flag;
        logic wd_disabled;
        logic [15:0] ctrl;
        logic dsft;
        logic stby_req;
        logic stby_sel;
        logic not_ready;
        logic discharge;
        logic cs_prev;
        logic reg_en;
        logic deep;
        logic active;
        logic blocks_en;
        logic [7:0] flags;
    } top_state_type;
    top_state_type state_reg;
    top_state_type state_next;
    logic cs_sync;
    logic trig_taken;
    logic fail_event;
    logic wd_enable;
    logic [6:0] fault_flags;
    logic [6:0] fault_clear;

    // Frame select is a pin: two flops before any edge logic sees it
    sync2 u_cs_sync (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .async_in(frame_select_pin_in),
        .sync_out(cs_sync)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_flag
            status_flag u_flag (
                .mclk_in(mclk_in),
                .srst_in(srst_in),
                .fault_in(fault_active_in[gi]),
                .clear_in(fault_clear[gi]),
                .flag_out(fault_flags[gi])
            );
            // Fault flag n sits at status bit n, so mask bit n selects it
            assign fault_clear[gi] = frame_clear_in && frame_clear_mask_in[gi];
        end
    endgenerate

    always_comb begin
        state_next = state_reg;
        trig_taken = 1'b0;
        fail_event = 1'b0;
        state_next.cs_prev = cs_sync;
        // Standby rule: compare bit one disables; zero follows the load current
        wd_enable = !flash_mode_in && !state_reg.wd_disabled;
        // A wake event ends light standby at once
        if (light_standby_in && !wake_event_in) begin
            if (standby_current_compare_bit_in || !regulator_load_current_high_in) begin
                wd_enable = 1'b0;
            end
        end
        // Off bit is only taken while in flash mode
        if (flash_mode_in) begin
            state_next.wd_disabled = watchdog_off_bit_in;
        end
        // Drain fault disable survives fail-safe and simply follows its input
        state_next.dsft = drain_fault_disable_bit_in;
        if (frame_clear_in && frame_clear_mask_in[7]) begin
            state_next.wdg_flag = 1'b0;
            state_next.failsafe = 1'b0;
        end
        // Self-clearing not-ready flag
        if (charge_pump_above_low_in) begin
            state_next.not_ready = 1'b0;
        end
        if (state_reg.reset_cnt != 8'h00) begin
            state_next.reset_cnt = state_reg.reset_cnt - 8'h01;
        end else begin
            state_next.reset_pin = 1'b1;
        end
        state_next.count = state_reg.count + 32'h1;
        // Frame end edge of frame select carries any trigger
        if (cs_sync && !state_reg.cs_prev) begin
            if (frame_toggle_write_in) begin
                state_next.toggle = frame_toggle_value_in;
                trig_taken = 1'b1;
            end
            if (frame_standby_write_in) begin
                state_next.stby_req = frame_standby_request_in;
                state_next.stby_sel = frame_standby_select_in;
            end
            if (frame_ctrl_write_in && !state_reg.failsafe) begin
                state_next.ctrl = frame_ctrl_data_in;
            end
        end

        case (state_reg.state)
            window_watchdog_pkg::WD_OFF: begin
                // Waits for an enable and for the reset pin to be released
                state_next.count = 32'h0;
                if (wd_enable && state_reg.reset_pin) begin
                    state_next.state = window_watchdog_pkg::WD_LONG_OPEN;
                end
            end
            window_watchdog_pkg::WD_LONG_OPEN: begin
                // The window only runs once the reset pulse is over, so the host gets all of it
                if (!state_reg.reset_pin) begin
                    state_next.count = 32'h0;
                end else if (trig_taken && frame_toggle_value_in) begin
                    state_next.state = window_watchdog_pkg::WD_CLOSED;
                    state_next.count = 32'h0;
                    state_next.fails = 4'h0;
                end else if (state_reg.count >= LONG_OPEN_CYC - 32'h1) begin
                    fail_event = 1'b1;
                end
                // A zero write leaves the window running untouched
            end
            window_watchdog_pkg::WD_CLOSED: begin
                // Any inversion this early is a failure; an equal write is ignored
                if (trig_taken && frame_toggle_value_in != state_reg.toggle) begin
                    fail_event = 1'b1;
                end else if (state_reg.count >= CLOSED_CYC - 32'h1) begin
                    state_next.state = window_watchdog_pkg::WD_OPEN;
                    state_next.count = 32'h0;
                end
            end
            window_watchdog_pkg::WD_OPEN: begin
                // Only an inversion counts as a trigger here
                if (trig_taken && frame_toggle_value_in != state_reg.toggle) begin
                    state_next.state = window_watchdog_pkg::WD_CLOSED;
                    state_next.count = 32'h0;
                    state_next.fails = 4'h0;
                end else if (state_reg.count >= OPEN_CYC - 32'h1) begin
                    fail_event = 1'b1;
                end
            end
            window_watchdog_pkg::WD_REG_OFF: begin
                // The regulator is off, so no trigger can arrive in this period
                if (state_reg.count >= REG_OFF_CYC - 32'h1) begin
                    state_next.state = window_watchdog_pkg::WD_LONG_OPEN;
                    state_next.count = 32'h0;
                end
            end
            window_watchdog_pkg::WD_DEEP: begin
                // Only a reset leaves deep standby; later failures are not counted
                state_next.count = 32'h0;
            end
            default: begin
                // An unused code recovers through the off state
                state_next.state = window_watchdog_pkg::WD_OFF;
            end
        endcase

        // Pulse, flag, restart and control reset all start in one cycle; the set beats a clear
        if (fail_event) begin
            state_next.fails = state_reg.fails + 4'h1;
            state_next.count = 32'h0;
            state_next.reset_pin = 1'b0;
            state_next.reset_cnt = 8'(`WDG_RESET_PULSE_CYC);
            state_next.wdg_flag = 1'b1;
            state_next.failsafe = 1'b1;
            state_next.state = window_watchdog_pkg::WD_LONG_OPEN;
            state_next.ctrl = `WDG_CTRL_DEFAULT;
            state_next.discharge = 1'b1;
            if (state_reg.fails + 4'h1 == `WDG_FAILS_REG_OFF) begin
                state_next.state = window_watchdog_pkg::WD_REG_OFF;
            end else if (state_reg.fails + 4'h1 == `WDG_FAILS_DEEP) begin
                state_next.state = window_watchdog_pkg::WD_DEEP;
            end
        end
        // Discharge holds for as long as fail-safe does
        if (!state_next.failsafe) begin
            state_next.discharge = 1'b0;
        end
        // Leaving enabled conditions parks the watchdog unless it is in regulator-off or deep standby; a later enable starts a long open window
        if (!wd_enable && state_reg.state != window_watchdog_pkg::WD_DEEP
                && state_reg.state != window_watchdog_pkg::WD_REG_OFF) begin
            state_next.state = window_watchdog_pkg::WD_OFF;
            state_next.count = 32'h0;
        end

        // Pin decodes come from the next state, so registering them adds no delay
        state_next.reg_en = state_next.state != window_watchdog_pkg::WD_REG_OFF
            && state_next.state != window_watchdog_pkg::WD_DEEP;
        state_next.deep = state_next.state == window_watchdog_pkg::WD_DEEP;
        state_next.active = state_next.state != window_watchdog_pkg::WD_OFF;
        state_next.blocks_en = !state_next.failsafe;
        state_next.flags = {state_next.wdg_flag, fault_flags[6:1], state_next.not_ready | fault_flags[0]};
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            // Pin released, regulator and blocks on, not-ready pending
            state_reg <= '0;
            state_reg.reset_pin <= 1'b1;
            state_reg.not_ready <= 1'b1;
            state_reg.ctrl <= `WDG_CTRL_DEFAULT;
            state_reg.cs_prev <= 1'b1;
            state_reg.reg_en <= 1'b1;
            state_reg.blocks_en <= 1'b1;
            state_reg.flags <= 8'h01;
        end else begin
            state_reg <= state_next;
        end
    end

    // Every pin is a state flop; fault bits of the status word lag their flags by one cycle
    assign reset_out_pin_out = state_reg.reset_pin;
    assign regulator_enable_out = state_reg.reg_en;
    assign deep_standby_out = state_reg.deep;
    assign failsafe_state_out = state_reg.failsafe;
    assign watchdog_toggle_bit_out = state_reg.toggle;
    assign failure_count_field_out = state_reg.fails;
    assign ctrl_word_out = state_reg.ctrl;
    assign drain_fault_disable_bit_out = state_reg.dsft;
    assign standby_request_bit_out = state_reg.stby_req;
    assign standby_select_bit_out = state_reg.stby_sel;
    assign blocks_enable_out = state_reg.blocks_en;
    assign gate_discharge_out = state_reg.discharge;
    assign status_flags_out = state_reg.flags;
    assign watchdog_active_out = state_reg.active;
endmodule
`default_nettype wire

// *** tb/window_watchdog_failsafe_assertions.sv ***
// Port-level checker for the window watchdog and its fail-safe reaction
`timescale 1ns/1ps
`default_nettype none
`include "window_watchdog_map.svh"
module window_watchdog_failsafe_checker #(
    parameter logic [31:0] REG_OFF_CYC = `WDG_REG_OFF_CYC
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic frame_select_pin_in,
    input wire logic frame_clear_in,
    input wire logic [7:0] frame_clear_mask_in,
    input wire logic flash_mode_in,
    input wire logic reset_out_pin_out,
    input wire logic regulator_enable_out,
    input wire logic deep_standby_out,
    input wire logic failsafe_state_out,
    input wire logic watchdog_toggle_bit_out,
    input wire logic [3:0] failure_count_field_out,
    input wire logic blocks_enable_out,
    input wire logic [7:0] status_flags_out,
    input wire logic watchdog_active_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    logic [31:0] low_cnt_reg, off_cnt_reg;
    logic [3:0] fs_age_reg;
    // Age saturates so a long idle stretch never wraps back into the legal range
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            low_cnt_reg <= 32'h0;
            off_cnt_reg <= 32'h0;
            fs_age_reg <= 4'hf;
        end else begin
            low_cnt_reg <= reset_out_pin_out ? 32'h0 : low_cnt_reg + 32'h1;
            off_cnt_reg <= regulator_enable_out ? 32'h0 : off_cnt_reg + 32'h1;
            fs_age_reg <= $rose(frame_select_pin_in) ? 4'h0 : (fs_age_reg == 4'hf ? 4'hf : fs_age_reg + 4'h1);
        end
    end
    sequence fail_start;
        $fell(reset_out_pin_out);
    endsequence
    sequence reg_back_on;
        $rose(regulator_enable_out);
    endsequence
    AST_PULSE_LEN: assert property ($rose(reset_out_pin_out) |-> low_cnt_reg inside {[`WDG_RESET_PULSE_CYC : `WDG_RESET_PULSE_CYC + 1]})
        else $error("reset pulse length wrong");
    AST_FAIL_LATCH: assert property (fail_start |-> ##[0:3] (failsafe_state_out && status_flags_out[7]))
        else $error("fail-safe flag not latched");
    AST_FS_BLOCKS: assert property (failsafe_state_out |-> !blocks_enable_out)
        else $error("blocks enabled in fail-safe");
    AST_COUNT_STEP: assert property ($changed(failure_count_field_out) |-> failure_count_field_out == 4'h0 || failure_count_field_out == $past(failure_count_field_out) + 4'h1)
        else $error("failure count jumped");
    AST_FLASH_OFF: assert property (flash_mode_in [*3] |-> !watchdog_active_out)
        else $error("watchdog active in flash mode");
    AST_REG_OFF_AT_8: assert property ($fell(regulator_enable_out) |-> ##[0:2] (failure_count_field_out == `WDG_FAILS_REG_OFF || deep_standby_out))
        else $error("regulator off at wrong count");
    AST_REG_OFF_LEN: assert property (reg_back_on |-> off_cnt_reg inside {[REG_OFF_CYC - 32'h1 : REG_OFF_CYC + 32'h1]})
        else $error("regulator off time wrong");
    AST_CLEAR_PER_BIT: assert property (frame_clear_in |=> ((($past(status_flags_out) & ~$past(frame_clear_mask_in)) & ~status_flags_out) & 8'hfe) == 8'h00)
        else $error("unselected flag cleared");
    AST_TRIG_AT_FRAME: assert property ($changed(watchdog_toggle_bit_out) |-> fs_age_reg inside {[4'h1 : 4'h8]})
        else $error("toggle bit moved without frame end");
endmodule
bind window_watchdog_failsafe window_watchdog_failsafe_checker #(.REG_OFF_CYC(REG_OFF_CYC)) u_chk (.mclk_in, .srst_in,
    .frame_select_pin_in, .frame_clear_in, .frame_clear_mask_in, .flash_mode_in, .reset_out_pin_out, .regulator_enable_out,
    .deep_standby_out, .failsafe_state_out, .watchdog_toggle_bit_out, .failure_count_field_out, .blocks_enable_out,
    .status_flags_out, .watchdog_active_out);
`default_nettype wire

// *** tb/host_spi_model.sv ***
// Host side of the frame interface: frames that may carry a watchdog toggle write
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
    input wire logic mclk_in,
    output logic frame_select_pin_out,
    output logic toggle_write_out,
    output logic toggle_value_out
);
    initial begin
        frame_select_pin_out = 1'b1;
        toggle_write_out = 1'b0;
        toggle_value_out = 1'b0;
    end
    // Payload held past the closing edge because the device samples behind its synchroniser
    task automatic frame(input logic write_toggle, input logic value, input int slow);
        @(negedge mclk_in);
        frame_select_pin_out = 1'b0;
        toggle_write_out = write_toggle;
        toggle_value_out = value;
        repeat (3 + slow) @(negedge mclk_in);
        frame_select_pin_out = 1'b1;
        repeat (4) @(negedge mclk_in);
        toggle_write_out = 1'b0;
        toggle_value_out = ~value;
    endtask
endmodule
`default_nettype wire

// *** tb/window_watchdog_failsafe_tb_top.sv ***
// Self-checking bench for the window watchdog with fail-safe reaction
`timescale 1ns/1ps
`default_nettype none
module window_watchdog_failsafe_tb_top;
    localparam logic [31:0] LONG_OPEN = 32'h32;
    logic mclk_in, srst_in, fsel, tw, tv, cw, sw, sr, ss, clr, flash, light, wake, cmp, load_hi, wd_off, dfd, cp_ok;
    logic [15:0] cd, ctrl_word;
    logic [7:0] mask, flags;
    logic [6:0] fault;
    logic rst_pin, reg_en, deep, fs_st, tgl, dfd_o, sreq, ssel, blk, gdis, wd_act;
    logic [3:0] cnt, cnt_prev;
    logic [3:0] exp_q[$];
    int fails = 0, tests_run = 0, cycles = 0;
    host_spi_model host (.mclk_in(mclk_in), .frame_select_pin_out(fsel), .toggle_write_out(tw), .toggle_value_out(tv));
    window_watchdog_failsafe #(.LONG_OPEN_CYC(LONG_OPEN), .CLOSED_CYC(32'ha), .OPEN_CYC(32'h14), .REG_OFF_CYC(32'h28)) dut (
        .mclk_in(mclk_in), .srst_in(srst_in), .frame_select_pin_in(fsel), .frame_toggle_write_in(tw),
        .frame_toggle_value_in(tv), .frame_ctrl_write_in(cw), .frame_ctrl_data_in(cd), .frame_standby_write_in(sw),
        .frame_standby_request_in(sr), .frame_standby_select_in(ss), .frame_clear_in(clr), .frame_clear_mask_in(mask),
        .flash_mode_in(flash), .light_standby_in(light), .wake_event_in(wake), .standby_current_compare_bit_in(cmp),
        .regulator_load_current_high_in(load_hi), .watchdog_off_bit_in(wd_off), .drain_fault_disable_bit_in(dfd),
        .charge_pump_above_low_in(cp_ok), .fault_active_in(fault), .reset_out_pin_out(rst_pin),
        .regulator_enable_out(reg_en), .deep_standby_out(deep), .failsafe_state_out(fs_st),
        .watchdog_toggle_bit_out(tgl), .failure_count_field_out(cnt), .ctrl_word_out(ctrl_word),
        .drain_fault_disable_bit_out(dfd_o), .standby_request_bit_out(sreq), .standby_select_bit_out(ssel),
        .blocks_enable_out(blk), .gate_discharge_out(gdis), .status_flags_out(flags), .watchdog_active_out(wd_act));
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    task automatic do_reset();
        @(negedge mclk_in) srst_in = 1'b1;
        tick(8);
        srst_in = 1'b0;
        tick(3);
    endtask
    task automatic pulse_clear(input logic [7:0] m);
        {clr, mask} = {1'b1, m};
        tick(1);
        clr = 1'b0;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #20 mclk_in = ~mclk_in;
    end
    // Every change of the failure count must match the oldest expected value
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 32'h4e20) begin
            fails++;
            summarize();
        end
        if (!srst_in && cnt !== cnt_prev) begin
            if (exp_q.size() == 0)
                check(20'h1, 20'h0);
            else
                check(cnt, exp_q.pop_front());
        end
        cnt_prev <= cnt;
    end
    initial begin
        logic [15:0] d;
        logic [7:0] m;
        {srst_in, cw, sw, sr, ss, clr, flash, light, wake, cmp, load_hi, wd_off, dfd, cp_ok} = 14'h2000;
        {cd, mask, fault} = 31'h0;
        void'($urandom(72753));
        do_reset();
        cp_ok = 1'b1;
        check(wd_act, 1'b1);
        host.frame(1'b1, 1'b0, 0);
        check(tgl, 1'b0);
        host.frame(1'b1, 1'b1, $urandom_range(2));
        check(tgl, 1'b1);
        // Same value inside the closed window must be neither trigger nor failure
        host.frame(1'b1, 1'b1, 0);
        tick(4);
        host.frame(1'b1, 1'b0, 0);
        check(tgl, 1'b0);
        exp_q.push_back(4'h1);
        host.frame(1'b1, 1'b1, 0);
        while (rst_pin !== 1'b0 && cycles < 2000) tick(1);
        tick(2);
        check({fs_st, flags[7], blk, gdis}, 4'hd);
        while (rst_pin !== 1'b1 && cycles < 2000) tick(1);
        d = 16'($urandom);
        {cw, cd, sw, sr, ss, dfd} = {1'b1, d, 4'hf};
        host.frame(1'b0, 1'b0, 0);
        {cw, sw} = 2'b00;
        check({ctrl_word, sreq, ssel, dfd_o}, {16'h0, 3'b111});
        pulse_clear(8'h80);
        tick(2);
        check({fs_st, flags[7]}, 2'b00);
        cw = 1'b1;
        host.frame(1'b0, 1'b0, 0);
        cw = 1'b0;
        check(ctrl_word, d);
        exp_q.push_back(4'h0);
        host.frame(1'b1, 1'b1, 0);
        // No more triggers: the count climbs through the regulator cycle to deep standby
        for (int i = 1; i < 16; i++) exp_q.push_back(4'(i));
        while (reg_en !== 1'b0 && cycles < 12000) tick(1);
        check({cnt, ctrl_word}, {4'h8, 16'h0});
        while (deep !== 1'b1 && cycles < 12000) tick(1);
        tick(200);
        check({deep, cnt, reg_en}, 6'h3e);
        do_reset();
        {flash, wd_off} = 2'b11;
        tick(3);
        check({wd_act, flags[0]}, 2'b00);
        flash = 1'b0;
        tick(int'(2 * LONG_OPEN));
        check(wd_act, 1'b0);
        {flash, wd_off} = 2'b00;
        do_reset();
        {light, cmp} = 2'b11;
        tick(3);
        check(wd_act, 1'b0);
        {cmp, load_hi} = 2'b01;
        tick(3);
        check(wd_act, 1'b1);
        load_hi = 1'b0;
        tick(3);
        check(wd_act, 1'b0);
        {light, wake} = 2'b01;
        tick(1);
        wake = 1'b0;
        tick(3);
        check(wd_act, 1'b1);
        {flash, fault} = 8'hfe;
        tick(2);
        pulse_clear(8'hff);
        fault = 7'h00;
        tick(2);
        check(flags[6:1], 6'h3f);
        m = {1'b0, 7'($urandom)};
        pulse_clear(m);
        tick(2);
        check(flags, 8'h7e & ~m);
        summarize();
    end
endmodule
`default_nettype wire
